//--- verilog/ced_pkg.sv
package ced_pkg;
  localparam logic [7:0] OFS_ERRCNT = 8'h00;
  localparam logic [7:0] OFS_DIAG = 8'h04;
  localparam logic [7:0] OFS_STAMP = 8'h08;
  localparam logic [7:0] OFS_GCFG = 8'h0c;
  localparam logic [7:0] OFS_IRQ = 8'h10;
  localparam logic [7:0] OFS_NODE = 8'h14;
  localparam int GCFG_EN = 0;
  localparam int GCFG_TSCLR = 1;
  localparam int GCFG_TXPOL = 2;
  localparam int GCFG_RXPOL = 3;
  localparam int IRQ_EN = 0;
  localparam int IRQ_PND = 1;
  localparam int DIAG_DRIVE = 14;
  localparam int DIAG_SAMPLED = 13;
  localparam int DIAG_CRC = 12;
  localparam int DIAG_STUFF = 11;
  localparam int DIAG_WAS_TX = 10;
  localparam int DIAG_POS_LSB = 4;
  localparam int DIAG_FIELD_LSB = 0;
  localparam int ERRCNT_IN_LSB = 8;
  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [15:0] STAMP_RST = 16'h0000;
  localparam logic [3:0] GCFG_RST = 4'h0;
  localparam logic [8:0] TALLY_WARN = 9'h060;
  localparam logic [8:0] TALLY_PASSIVE = 9'h080;
  localparam logic [8:0] TALLY_BUSOFF = 9'h100;
  localparam logic [2:0] NODE_OFF = 3'h0;
  localparam logic [2:0] NODE_ACTIVE = 3'h2;
  localparam logic [2:0] NODE_WARN = 3'h3;
  localparam logic [2:0] NODE_PASSIVE = 3'h4;
  localparam logic [2:0] NODE_BUSOFF = 3'h6;

  typedef enum logic [3:0] {
    FLD_ERROR = 4'h0, FLD_ERR_DEL = 4'h1, FLD_ERR_ECHO = 4'h2, FLD_IDLE = 4'h3,
    FLD_ACK = 4'h4, FLD_EOF = 4'h5, FLD_INTERMISSION = 4'h6, FLD_SUSPEND = 4'h7,
    FLD_SOF = 4'h8, FLD_ARB = 4'h9, FLD_IDE = 4'ha, FLD_EXT_ARB = 4'hb,
    FLD_RES = 4'hc, FLD_DLC = 4'hd, FLD_DATA = 4'he, FLD_CRC = 4'hf
  } ced_field_e;

  typedef enum logic [2:0] {
    EV_NONE = 3'h0, EV_RX_ERR1 = 3'h1, EV_RX_ERR8 = 3'h2, EV_TX_ERR8 = 3'h3,
    EV_RX_OK = 3'h4, EV_TX_OK = 3'h5
  } ced_cnt_ev_e;

  // status from the protocol engine, same clock
  typedef struct packed {
    logic bit_tick;
    logic field_start;
    ced_field_e field;
    logic [6:0] field_len;
    logic transmitter;
    logic stuff_err;
    logic crc_err;
    logic err_detect;
    logic tx_bit;
    logic frame_ok;
    logic [3:0] frame_buf;
    ced_cnt_ev_e cnt_ev;
  } ced_eng_s;

  typedef struct packed {
    logic [3:0] buf_idx;
    logic [15:0] value;
  } ced_stamp_s;
endpackage

//--- verilog/ced_sync.sv
`timescale 1ns/1ns
module ced_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync_out;

  // first stage feeds only the second
  always_comb
  begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= 1'b1;
      sync_out <= 1'b1;
    end
    else if (ce)
    begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule

//--- verilog/ced_bitpos.sv
`timescale 1ns/1ns
module ced_bitpos #(
  parameter int POS_W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [POS_W:0] len,
  input wire logic tick,
  output logic [POS_W-1:0] pos
);
  logic [POS_W-1:0] next_pos;
  logic [POS_W:0] len_m1;

  // refused at elaboration: wider position fields are not served
  if (POS_W < 1 || POS_W > 8)
  begin
    $error("ced_bitpos: POS_W out of range");
  end

  assign len_m1 = len - 1'b1;

  always_comb
  begin
    next_pos = pos;
    if (load)
      next_pos = len_m1[POS_W-1:0];
    else if (tick)
      next_pos = pos - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pos <= '0;
    else if (ce)
      pos <= next_pos;
  end
endmodule

//--- verilog/ced_top.sv
`timescale 1ns/1ns
module ced_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire ced_pkg::ced_eng_s ENG,
  input wire logic BUS_RX_PIN,
  output logic BUS_TX_PIN,
  output logic RX_BUS_LEVEL,
  output logic ERR_IRQ,
  output logic STAMP_WR,
  output ced_pkg::ced_stamp_s STAMP
);
  logic [7:0] inbound_error_tally;
  logic [8:0] outbound_error_tally;
  logic [15:0] error_diag_reg;
  logic [15:0] bit_time_stamp_counter;
  logic [3:0] global_config_reg;
  logic error_irq_enable;
  logic error_irq_pending;
  logic [7:0] next_inbound_error_tally;
  logic [8:0] next_outbound_error_tally;
  logic [15:0] next_error_diag_reg;
  logic [15:0] next_bit_time_stamp_counter;
  logic [3:0] next_global_config_reg;
  logic next_error_irq_enable;
  logic next_error_irq_pending;
  logic [2:0] node_state;
  logic [2:0] next_node_state;
  logic next_err_irq;
  logic next_bus_tx_pin;
  logic next_rx_bus_level;
  logic next_stamp_wr;
  ced_pkg::ced_stamp_s next_stamp;
  logic rx_sync;
  logic [5:0] error_bit_position;
  logic enabled;
  logic tx_polarity_select;
  logic rx_polarity_select;
  logic stamp_clear_on_buf0;
  logic rx_bus;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_valid;
  logic wr_hit;
  logic [7:0] tally8_out;

  assign enabled = global_config_reg[ced_pkg::GCFG_EN];
  assign stamp_clear_on_buf0 = global_config_reg[ced_pkg::GCFG_TSCLR];
  assign tx_polarity_select = global_config_reg[ced_pkg::GCFG_TXPOL];
  assign rx_polarity_select = global_config_reg[ced_pkg::GCFG_RXPOL];

  ced_sync u_rx_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .async_in(BUS_RX_PIN),
    .sync_out(rx_sync)
  );

  ced_bitpos #(
    .POS_W(6)
  ) u_bitpos (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .load(enabled & ENG.field_start),
    .len(ENG.field_len),
    .tick(enabled & ENG.bit_tick),
    .pos(error_bit_position)
  );

  assign rx_bus = enabled ? (rx_sync ^ rx_polarity_select) : 1'b1;

  // bus slave: zero wait, read data fetched in the address phase
  assign addr_valid = HSEL & HTRANS[1] & HREADY;
  assign wr_hit = wr_pend;

  always_comb
  begin
    next_wr_pend = addr_valid & HWRITE;
    next_wr_addr = addr_valid ? HADDR[7:0] : wr_addr;
    next_hrdata = 32'h0000_0000;
    if (addr_valid & ~HWRITE)
    begin
      unique case (HADDR[7:0])
        ced_pkg::OFS_ERRCNT:
          next_hrdata = {16'h0000, inbound_error_tally, tally8_out};
        ced_pkg::OFS_DIAG:
          next_hrdata = {16'h0000, error_diag_reg};
        ced_pkg::OFS_STAMP:
          next_hrdata = {16'h0000, bit_time_stamp_counter};
        ced_pkg::OFS_GCFG:
          next_hrdata = {28'h0000000, global_config_reg};
        ced_pkg::OFS_IRQ:
          next_hrdata = {30'h0, error_irq_pending, error_irq_enable};
        ced_pkg::OFS_NODE:
          next_hrdata = {29'h0, node_state};
        default:
          next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else if (CE)
    begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      HRDATA <= next_hrdata;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // displayed transmit tally saturates; bus-off lives in bit 8
  assign tally8_out = outbound_error_tally[8] ? 8'hff : outbound_error_tally[7:0];

  // configuration; only reset or a bus write changes it
  always_comb
  begin
    next_global_config_reg = global_config_reg;
    next_error_irq_enable = error_irq_enable;
    if (wr_hit && wr_addr == ced_pkg::OFS_GCFG)
      next_global_config_reg = HWDATA[3:0];
    if (wr_hit && wr_addr == ced_pkg::OFS_IRQ)
      next_error_irq_enable = HWDATA[ced_pkg::IRQ_EN];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      global_config_reg <= ced_pkg::GCFG_RST;
      error_irq_enable <= 1'b0;
    end
    else if (CE)
    begin
      global_config_reg <= next_global_config_reg;
      error_irq_enable <= next_error_irq_enable;
    end
  end

  // tallies follow the engine's fault confinement events
  always_comb
  begin
    next_inbound_error_tally = inbound_error_tally;
    next_outbound_error_tally = outbound_error_tally;
    if (enabled)
    begin
      unique case (ENG.cnt_ev)
        ced_pkg::EV_RX_ERR1:
          if (inbound_error_tally != 8'hff)
            next_inbound_error_tally = inbound_error_tally + 8'h01;
        ced_pkg::EV_RX_ERR8:
          next_inbound_error_tally = (inbound_error_tally > 8'hf7) ? 8'hff
            : inbound_error_tally + 8'h08;
        ced_pkg::EV_TX_ERR8:
          next_outbound_error_tally = (outbound_error_tally > 9'h1f7) ? 9'h1ff
            : outbound_error_tally + 9'h008;
        ced_pkg::EV_RX_OK:
          if (inbound_error_tally != 8'h00)
            next_inbound_error_tally = inbound_error_tally - 8'h01;
        ced_pkg::EV_TX_OK:
          if (outbound_error_tally != 9'h000)
            next_outbound_error_tally = outbound_error_tally - 9'h001;
        default:
          next_inbound_error_tally = inbound_error_tally;
      endcase
    end
  end

  // change sets pending, set beats clear
  always_comb
  begin
    next_error_irq_pending = error_irq_pending;
    if (wr_hit && wr_addr == ced_pkg::OFS_IRQ && HWDATA[ced_pkg::IRQ_PND])
      next_error_irq_pending = 1'b0;
    if (next_inbound_error_tally != inbound_error_tally ||
        next_outbound_error_tally != outbound_error_tally)
      next_error_irq_pending = 1'b1;
    next_err_irq = next_error_irq_pending & next_error_irq_enable;
  end

  always_comb
  begin
    if (!enabled)
      next_node_state = ced_pkg::NODE_OFF;
    else if (next_outbound_error_tally >= ced_pkg::TALLY_BUSOFF)
      next_node_state = ced_pkg::NODE_BUSOFF;
    else if (next_outbound_error_tally >= ced_pkg::TALLY_PASSIVE ||
             {1'b0, next_inbound_error_tally} >= ced_pkg::TALLY_PASSIVE)
      next_node_state = ced_pkg::NODE_PASSIVE;
    else if (next_outbound_error_tally >= ced_pkg::TALLY_WARN ||
             {1'b0, next_inbound_error_tally} >= ced_pkg::TALLY_WARN)
      next_node_state = ced_pkg::NODE_WARN;
    else
      next_node_state = ced_pkg::NODE_ACTIVE;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      inbound_error_tally <= 8'h00;
      outbound_error_tally <= 9'h000;
      error_irq_pending <= 1'b0;
      ERR_IRQ <= 1'b0;
      node_state <= ced_pkg::NODE_OFF;
    end
    else if (CE)
    begin
      inbound_error_tally <= next_inbound_error_tally;
      outbound_error_tally <= next_outbound_error_tally;
      error_irq_pending <= next_error_irq_pending;
      ERR_IRQ <= next_err_irq;
      node_state <= next_node_state;
    end
  end

  // diagnostic snapshot; only a new error overwrites
  // packed diagnostic layout
  always_comb
  begin
    next_error_diag_reg = error_diag_reg;
    if (enabled & ENG.err_detect)
    begin
      next_error_diag_reg = 16'h0000;
      next_error_diag_reg[ced_pkg::DIAG_FIELD_LSB +: 4] = ENG.field;
      next_error_diag_reg[ced_pkg::DIAG_POS_LSB +: 6] = error_bit_position;
      next_error_diag_reg[ced_pkg::DIAG_WAS_TX] = ENG.transmitter;
      next_error_diag_reg[ced_pkg::DIAG_STUFF] = ENG.stuff_err;
      next_error_diag_reg[ced_pkg::DIAG_CRC] = ENG.crc_err;
      next_error_diag_reg[ced_pkg::DIAG_SAMPLED] = rx_bus;
      next_error_diag_reg[ced_pkg::DIAG_DRIVE] = BUS_TX_PIN;
    end
  end

  always_comb
  begin
    next_bus_tx_pin = (enabled ? ENG.tx_bit : 1'b1) ^ tx_polarity_select;
    next_rx_bus_level = rx_bus;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      error_diag_reg <= ced_pkg::DIAG_RST;
      BUS_TX_PIN <= 1'b1;
      RX_BUS_LEVEL <= 1'b1;
    end
    else if (CE)
    begin
      error_diag_reg <= next_error_diag_reg;
      BUS_TX_PIN <= next_bus_tx_pin;
      RX_BUS_LEVEL <= next_rx_bus_level;
    end
  end

  // stamp counter; the copy takes the value before any clear
  always_comb
  begin
    next_bit_time_stamp_counter = bit_time_stamp_counter;
    next_stamp_wr = 1'b0;
    next_stamp = STAMP;
    if (enabled & ENG.bit_tick)
      next_bit_time_stamp_counter = bit_time_stamp_counter + 16'h0001;
    if (enabled & ENG.frame_ok)
    begin
      next_stamp_wr = 1'b1;
      next_stamp.buf_idx = ENG.frame_buf;
      next_stamp.value = bit_time_stamp_counter;
      if (stamp_clear_on_buf0 && ENG.frame_buf == 4'h0)
        next_bit_time_stamp_counter = 16'h0000;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      bit_time_stamp_counter <= ced_pkg::STAMP_RST;
      STAMP_WR <= 1'b0;
      STAMP <= '0;
    end
    else if (CE)
    begin
      bit_time_stamp_counter <= next_bit_time_stamp_counter;
      STAMP_WR <= next_stamp_wr;
      STAMP <= next_stamp;
    end
  end
endmodule

//--- tb/ced_xcvr.sv
`timescale 1ns/1ns
module ced_xcvr (
  input wire logic tx,
  input wire logic dom,
  output logic rx
);
  // wired-and bus
  // a far node's dominant bit wins over our recessive drive
  assign rx = tx & ~dom;
endmodule

//--- tb/ced_top_assertions.sv
`timescale 1ns/1ns
module ced_top_assertions (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire ced_pkg::ced_eng_s ENG,
  input wire logic BUS_TX_PIN,
  input wire logic RX_BUS_LEVEL,
  input wire logic STAMP_WR,
  input wire ced_pkg::ced_stamp_s STAMP
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  property p_resp_okay;
    HRESP == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("bus response not okay");
  property p_zero_wait;
    HREADYOUT == 1'b1;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("slave inserted wait state");
  property p_rdata_src;
    HRDATA != 32'h0 |-> $past(HSEL && HTRANS[1] && !HWRITE && HREADY);
  endproperty
  a_rdata_src: assert property (p_rdata_src)
    else $error("read data outside read data phase");
  property p_stamp_src;
    STAMP_WR |-> $past(ENG.frame_ok);
  endproperty
  a_stamp_src: assert property (p_stamp_src)
    else $error("stamp write without finished frame");
  property p_stamp_idx;
    STAMP_WR |-> STAMP.buf_idx == $past(ENG.frame_buf);
  endproperty
  a_stamp_idx: assert property (p_stamp_idx)
    else $error("stamp sent to wrong buffer");
  property p_stamp_hold;
    !STAMP_WR |-> $stable(STAMP);
  endproperty
  a_stamp_hold: assert property (p_stamp_hold)
    else $error("stamp changed without write");
  property p_reset_vals;
    $fell(RST) |-> BUS_TX_PIN && RX_BUS_LEVEL && !STAMP_WR && STAMP == '0 && HRDATA == 32'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset values");
  property p_tx_change;
    $changed(BUS_TX_PIN) |-> $past(ENG.tx_bit) != $past(ENG.tx_bit, 2)
      || $past(HSEL && HTRANS[1] && HWRITE, 2) || $past(HSEL && HTRANS[1] && HWRITE, 3);
  endproperty
  a_tx_change: assert property (p_tx_change)
    else $error("transmit pin changed without cause");
endmodule
bind ced_top ced_top_assertions u_chk (.CLK_SYS, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY,
  .HRDATA, .HREADYOUT, .HRESP, .ENG, .BUS_TX_PIN, .RX_BUS_LEVEL, .STAMP_WR, .STAMP);

//--- tb/can_error_diag_timestamp_tb_top.sv
`timescale 1ns/1ns
module can_error_diag_timestamp_tb_top;
  logic clk, rst, hsel, hwrite, dom, ce;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rdata, hrdata;
  logic hreadyout, hresp, tx_pin, rx_pin, rx_lvl, irq, stamp_wr;
  ced_pkg::ced_eng_s eng;
  ced_pkg::ced_stamp_s stamp;
  int miscompares = 0;
  int cmp_count = 0;
  ced_top uut (.CLK_SYS(clk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ENG(eng), .BUS_RX_PIN(rx_pin), .BUS_TX_PIN(tx_pin),
    .RX_BUS_LEVEL(rx_lvl), .ERR_IRQ(irq), .STAMP_WR(stamp_wr), .STAMP(stamp));
  ced_xcvr u_xcvr (.tx(tx_pin), .dom(dom), .rx(rx_pin));
  always #5 clk = ~clk;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdata = hrdata;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(nm, exp, rdata);
  endtask
  // pulses last exactly one cycle, then a quiet cycle
  task automatic strobe();
    @(posedge clk);
    eng.bit_tick <= 1'b0;
    eng.field_start <= 1'b0;
    eng.err_detect <= 1'b0;
    eng.frame_ok <= 1'b0;
    eng.cnt_ev <= ced_pkg::EV_NONE;
    @(posedge clk);
  endtask
  initial
  begin
    clk = 0;
    rst = 1;
    hsel = 0;
    htrans = 0;
    haddr = 0;
    hwrite = 0;
    hwdata = 0;
    eng = '0;
    dom = 0;
    ce = 1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("errcnt", ced_pkg::OFS_ERRCNT, 32'h0);
    rd_chk("diag", ced_pkg::OFS_DIAG, 32'h0);
    rd_chk("stamp", ced_pkg::OFS_STAMP, 32'h0);
    rd_chk("unmapped", 8'h3c, 32'h0);
    ahb(1'b1, ced_pkg::OFS_DIAG, 32'hffff);
    rd_chk("diag_ro", ced_pkg::OFS_DIAG, 32'h0);
    ahb(1'b1, ced_pkg::OFS_GCFG, 32'h1);
    rd_chk("gcfg", ced_pkg::OFS_GCFG, 32'h1);
    // every counting event once: rx +1 +8 -1, tx +8 -1
    for (int i = 1; i < 6; i++)
    begin
      eng.cnt_ev <= ced_pkg::ced_cnt_ev_e'(i);
      strobe();
    end
    rd_chk("errcnt", ced_pkg::OFS_ERRCNT, 32'h0807);
    rd_chk("node_act", ced_pkg::OFS_NODE, 32'h2);
    rd_chk("irq_pend", ced_pkg::OFS_IRQ, 32'h2);
    ahb(1'b1, ced_pkg::OFS_IRQ, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_pin", 32'h1, {31'h0, irq});
    ahb(1'b1, ced_pkg::OFS_IRQ, 32'h3);
    rd_chk("irq_clr", ced_pkg::OFS_IRQ, 32'h1);
    check("irq_pin", 32'h0, {31'h0, irq});
    // every field code, flags and bit position varied
    for (int f = 0; f < 16; f++)
    begin
      logic [3:0] b;
      b = 4'(f);
      eng.field <= ced_pkg::ced_field_e'(b);
      eng.field_len <= 7'(f + 2);
      eng.transmitter <= b[0];
      eng.stuff_err <= b[1];
      eng.crc_err <= b[2];
      eng.tx_bit <= b[3];
      dom <= b[0] ^ b[1];
      eng.field_start <= 1'b1;
      strobe();
      eng.bit_tick <= 1'b1;
      strobe();
      repeat (3) @(posedge clk);
      eng.err_detect <= 1'b1;
      strobe();
      rd_chk("diag", ced_pkg::OFS_DIAG, {17'h0, b[3], b[3] & ~(b[0] ^ b[1]), b[2], b[1], b[0],
        6'(f), b});
    end
    repeat (2) rd_chk("stamp", ced_pkg::OFS_STAMP, 32'h10);
    rd_chk("diag_keep", ced_pkg::OFS_DIAG, 32'h7cff);
    eng.frame_buf <= 4'h5;
    eng.frame_ok <= 1'b1;
    @(posedge clk);
    eng.frame_ok <= 1'b0;
    // the write strobe stands one cycle: look mid-cycle
    @(negedge clk);
    check("stamp_wr", 32'h1, {31'h0, stamp_wr});
    check("stamp_val", 32'h50010, 32'(stamp));
    @(negedge clk);
    check("stamp_wr_end", 32'h0, {31'h0, stamp_wr});
    @(posedge clk);
    rd_chk("no_clear", ced_pkg::OFS_STAMP, 32'h10);
    ahb(1'b1, ced_pkg::OFS_GCFG, 32'h3);
    eng.frame_ok <= 1'b1;
    strobe();
    rd_chk("other_buf", ced_pkg::OFS_STAMP, 32'h10);
    eng.frame_buf <= 4'h0;
    eng.frame_ok <= 1'b1;
    strobe();
    rd_chk("cleared", ced_pkg::OFS_STAMP, 32'h0);
    ahb(1'b1, ced_pkg::OFS_GCFG, 32'hd);
    eng.tx_bit <= 1'b0;
    dom <= 1'b0;
    repeat (5) @(posedge clk);
    check("tx_pol", 32'h1, {31'h0, tx_pin});
    check("rx_pol", 32'h0, {31'h0, rx_lvl});
    ahb(1'b1, ced_pkg::OFS_GCFG, 32'h0); // no frame pending here
    dom <= 1'b1;
    eng.bit_tick <= 1'b1;
    strobe();
    repeat (4) @(posedge clk);
    check("rx_off", 32'h1, {31'h0, rx_lvl});
    check("tx_off", 32'h1, {31'h0, tx_pin});
    rd_chk("stamp_off", ced_pkg::OFS_STAMP, 32'h0);
    rd_chk("errcnt_kept", ced_pkg::OFS_ERRCNT, 32'h0807);
    rd_chk("irq_kept", ced_pkg::OFS_IRQ, 32'h1);
    rd_chk("node_off", ced_pkg::OFS_NODE, 32'h0);
    ahb(1'b1, ced_pkg::OFS_GCFG, 32'h1);
    // transmit tally 7 + 8k walks through warning, passive and bus-off
    for (int k = 1; k <= 32; k++)
    begin
      logic [31:0] exp_node;
      exp_node = (k < 12) ? 32'h2 : (k < 16) ? 32'h3 : (k < 32) ? 32'h4 : 32'h6;
      eng.cnt_ev <= ced_pkg::EV_TX_ERR8;
      strobe();
      rd_chk("node", ced_pkg::OFS_NODE, exp_node);
    end
    rd_chk("errcnt_sat", ced_pkg::OFS_ERRCNT, 32'h08ff);
    // clock enable low must freeze the bit counter
    ce <= 1'b0;
    eng.bit_tick <= 1'b1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    eng.bit_tick <= 1'b0;
    @(posedge clk);
    rd_chk("ce_freeze", ced_pkg::OFS_STAMP, 32'h0);
    stop_test();
  end
endmodule
